// [shared/rtx_pkg.sv]
// Constants for the register transfer and RAM address executor.
// Assumes 10-bit instruction words and a 4-bit data path.
package rtx_pkg;
    // ----------------------------------------
    // Fixed opcodes
    // ----------------------------------------
    localparam logic [9:0] OP_COPY_B_TO_ACC = 10'h01E;
    localparam logic [9:0] OP_COPY_ACC_TO_B = 10'h00E;
    localparam logic [9:0] OP_COPY_Y_TO_ACC = 10'h01F;
    localparam logic [9:0] OP_COPY_ACC_TO_Y = 10'h00C;
    localparam logic [9:0] OP_PACK = 10'h01A;
    localparam logic [9:0] OP_UNPACK = 10'h02A;
    localparam logic [9:0] OP_COPY_ACC_TO_D = 10'h029;
    localparam logic [9:0] OP_COPY_D_TO_ACC = 10'h051;
    localparam logic [9:0] OP_COPY_Z_TO_ACC = 10'h053;
    localparam logic [9:0] OP_COPY_X_TO_ACC = 10'h052;
    localparam logic [9:0] OP_READ_STACK = 10'h050;
    localparam logic [9:0] OP_INCREMENT_Y = 10'h013;
    localparam logic [9:0] OP_DECREMENT_Y = 10'h017;
    // ----------------------------------------
    // Opcodes with immediate fields
    // ----------------------------------------
    localparam logic [9:0] MASK_LOAD_XY = 10'h300;
    localparam logic [9:0] OP_LOAD_XY = 10'h300;
    localparam logic [9:0] MASK_LOAD_Z = 10'h3FC;
    localparam logic [9:0] OP_LOAD_Z = 10'h048;
    localparam logic [9:0] MASK_RAM = 10'h3F0;
    localparam logic [9:0] OP_RAM_TO_ACC = 10'h2C0;
    localparam logic [9:0] OP_SWAP = 10'h2D0;
    localparam logic [9:0] OP_SWAP_DEC = 10'h2F0;
    localparam logic [9:0] OP_SWAP_INC = 10'h2E0;
    localparam logic [9:0] OP_ACC_TO_RAM = 10'h2B0;
    // ----------------------------------------
    // Field positions and values
    // ----------------------------------------
    localparam int IMM_X_MSB = 7;
    localparam int IMM_X_LSB = 4;
    localparam int IMM_Y_MSB = 3;
    localparam int IMM_Y_LSB = 0;
    localparam int IMM_Z_MSB = 1;
    localparam int WIDE_HI_MSB = 7;
    localparam int WIDE_HI_LSB = 4;
    localparam int WIDE_LO_MSB = 3;
    localparam int D_MSB = 2;
    localparam logic [3:0] Y_STEP = 4'h1;
    localparam logic [3:0] Y_WRAP_UP = 4'h0;
    localparam logic [3:0] Y_WRAP_DOWN = 4'hF;
    localparam logic [3:0] NIBBLE_RST = 4'h0;
    localparam logic [2:0] D_RST = 3'h0;
    localparam logic [1:0] Z_RST = 2'h0;
    localparam logic [7:0] WIDE_RST = 8'h00;
endpackage

// [rtl/rtx_exec.sv]
// Executor for register transfer, RAM address and RAM transfer instructions.
// Assumes instructions arrive on the instruction clock, one per valid cycle,
// and the RAM answers combinationally at the pointer address.
//
// Summary of operation
// - Copy B into accumulator
// - Copy accumulator into B
// - Copy Y into accumulator
// - Copy accumulator into Y
// - Pack B high, accumulator low into wide
// - Unpack wide into B and accumulator
// - Accumulator low three bits into D
// - D into accumulator, bit three zero
// - Z into accumulator, upper bits zero
// - Stack level into accumulator, bit three zero
// - Load X and Y from immediates
// - RAM to accumulator, X xor immediate
// - Swap accumulator and RAM, X xor immediate
// - Swap, X xor immediate, decrement Y
// - Swap, X xor immediate, increment Y
// - Accumulator to RAM, X xor immediate
// - Load Z from low two bits
// - Consecutive X/Y loads: only first executes
// - Increment Y, skip next on zero
// - Decrement Y, skip next on fifteen
`timescale 1ns/1ns
module rtx_exec (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Instruction stream
    input wire logic [9:0] instr_in,
    input wire logic instr_valid_in,
    // Stack level and RAM read data
    input wire logic [2:0] stack_level_in,
    input wire logic [3:0] ram_rdata_in,
    // Register state
    output logic [3:0] acc_out,
    output logic [3:0] b_out,
    output logic [3:0] x_out,
    output logic [3:0] y_out,
    output logic [1:0] z_out,
    output logic [2:0] d_out,
    output logic [7:0] wide_out,
    output logic skip_out,
    // RAM access
    output logic [9:0] ram_pointer_out,
    output logic [3:0] ram_wdata_out,
    output logic ram_we_out
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [3:0] acc_reg;
    logic [3:0] b_reg;
    logic [3:0] x_reg;
    logic [3:0] y_reg;
    logic [1:0] z_reg;
    logic [2:0] d_reg;
    logic [7:0] wide_reg;
    logic skip_reg;
    logic prev_lxy_reg;
    logic [3:0] acc_next;
    logic [3:0] b_next;
    logic [3:0] x_next;
    logic [3:0] y_next;
    logic [1:0] z_next;
    logic [2:0] d_next;
    logic [7:0] wide_next;
    logic skip_next;
    logic prev_lxy_next;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire logic copy_b_to_acc = instr_in == rtx_pkg::OP_COPY_B_TO_ACC;
    wire logic copy_acc_to_b = instr_in == rtx_pkg::OP_COPY_ACC_TO_B;
    wire logic copy_y_to_acc = instr_in == rtx_pkg::OP_COPY_Y_TO_ACC;
    wire logic copy_acc_to_y = instr_in == rtx_pkg::OP_COPY_ACC_TO_Y;
    wire logic pack_b_acc_wide = instr_in == rtx_pkg::OP_PACK;
    wire logic unpack_wide_to_b_acc = instr_in == rtx_pkg::OP_UNPACK;
    wire logic copy_acc_to_d = instr_in == rtx_pkg::OP_COPY_ACC_TO_D;
    wire logic copy_d_to_acc = instr_in == rtx_pkg::OP_COPY_D_TO_ACC;
    wire logic copy_z_to_acc = instr_in == rtx_pkg::OP_COPY_Z_TO_ACC;
    wire logic copy_x_to_acc = instr_in == rtx_pkg::OP_COPY_X_TO_ACC;
    wire logic read_stack_level = instr_in == rtx_pkg::OP_READ_STACK;
    wire logic increment_y = instr_in == rtx_pkg::OP_INCREMENT_Y;
    wire logic decrement_y = instr_in == rtx_pkg::OP_DECREMENT_Y;
    wire logic load_x_y_immediate = (instr_in & rtx_pkg::MASK_LOAD_XY) == rtx_pkg::OP_LOAD_XY;
    wire logic load_z_immediate = (instr_in & rtx_pkg::MASK_LOAD_Z) == rtx_pkg::OP_LOAD_Z;
    wire logic [9:0] ram_op = instr_in & rtx_pkg::MASK_RAM;
    wire logic ram_to_acc_xor_x = ram_op == rtx_pkg::OP_RAM_TO_ACC;
    wire logic swap_acc_ram_xor_x = ram_op == rtx_pkg::OP_SWAP;
    wire logic swap_acc_ram_dec_y = ram_op == rtx_pkg::OP_SWAP_DEC;
    wire logic swap_acc_ram_inc_y = ram_op == rtx_pkg::OP_SWAP_INC;
    wire logic acc_to_ram_xor_x = ram_op == rtx_pkg::OP_ACC_TO_RAM;

    // ----------------------------------------
    // Execution control
    // ----------------------------------------
    wire logic lxy_chain = load_x_y_immediate & prev_lxy_reg;
    wire logic exec = instr_valid_in & ~skip_reg & ~lxy_chain;
    wire logic any_swap = swap_acc_ram_xor_x | swap_acc_ram_dec_y | swap_acc_ram_inc_y;
    wire logic ram_read = ram_to_acc_xor_x | any_swap;
    wire logic x_xor = ram_read | acc_to_ram_xor_x;
    wire logic y_up = increment_y | swap_acc_ram_inc_y;
    wire logic y_down = decrement_y | swap_acc_ram_dec_y;
    wire logic [3:0] y_inc = y_reg + rtx_pkg::Y_STEP;
    wire logic [3:0] y_dec = y_reg - rtx_pkg::Y_STEP;
    wire logic [3:0] imm_x = instr_in[rtx_pkg::IMM_X_MSB:rtx_pkg::IMM_X_LSB];
    wire logic [3:0] imm_y = instr_in[rtx_pkg::IMM_Y_MSB:rtx_pkg::IMM_Y_LSB];
    wire logic [1:0] imm_z = instr_in[rtx_pkg::IMM_Z_MSB:rtx_pkg::IMM_Y_LSB];
    wire logic [3:0] wide_hi = wide_reg[rtx_pkg::WIDE_HI_MSB:rtx_pkg::WIDE_HI_LSB];
    wire logic [3:0] wide_lo = wide_reg[rtx_pkg::WIDE_LO_MSB:0];

    // ----------------------------------------
    // Next values
    // ----------------------------------------
    assign acc_next = !exec ? acc_reg :
        copy_b_to_acc ? b_reg :
        copy_y_to_acc ? y_reg :
        copy_x_to_acc ? x_reg :
        unpack_wide_to_b_acc ? wide_lo :
        copy_d_to_acc ? {1'b0, d_reg} :
        copy_z_to_acc ? {2'b00, z_reg} :
        read_stack_level ? {1'b0, stack_level_in} :
        ram_read ? ram_rdata_in :
        acc_reg;
    assign b_next = !exec ? b_reg :
        copy_acc_to_b ? acc_reg :
        unpack_wide_to_b_acc ? wide_hi :
        b_reg;
    assign y_next = !exec ? y_reg :
        load_x_y_immediate ? imm_y :
        copy_acc_to_y ? acc_reg :
        y_up ? y_inc :
        y_down ? y_dec :
        y_reg;
    assign x_next = !exec ? x_reg :
        load_x_y_immediate ? imm_x :
        x_xor ? x_reg ^ imm_y :
        x_reg;
    assign z_next = (exec & load_z_immediate) ? imm_z : z_reg;
    assign d_next = (exec & copy_acc_to_d) ? acc_reg[rtx_pkg::D_MSB:0] : d_reg;
    assign wide_next = (exec & pack_b_acc_wide) ? {b_reg, acc_reg} : wide_reg;
    assign skip_next = !instr_valid_in ? skip_reg :
        exec & ((y_up & (y_inc == rtx_pkg::Y_WRAP_UP)) |
        (y_down & (y_dec == rtx_pkg::Y_WRAP_DOWN)));
    assign prev_lxy_next = instr_valid_in ? load_x_y_immediate : prev_lxy_reg;

    // ----------------------------------------
    // State
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_reg <= rtx_pkg::NIBBLE_RST;
            b_reg <= rtx_pkg::NIBBLE_RST;
            x_reg <= rtx_pkg::NIBBLE_RST;
            y_reg <= rtx_pkg::NIBBLE_RST;
            z_reg <= rtx_pkg::Z_RST;
            d_reg <= rtx_pkg::D_RST;
            wide_reg <= rtx_pkg::WIDE_RST;
            skip_reg <= 1'b0;
            prev_lxy_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            b_reg <= b_next;
            x_reg <= x_next;
            y_reg <= y_next;
            z_reg <= z_next;
            d_reg <= d_next;
            wide_reg <= wide_next;
            skip_reg <= skip_next;
            prev_lxy_reg <= prev_lxy_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign acc_out = acc_reg;
    assign b_out = b_reg;
    assign x_out = x_reg;
    assign y_out = y_reg;
    assign z_out = z_reg;
    assign d_out = d_reg;
    assign wide_out = wide_reg;
    assign skip_out = skip_reg;
    assign ram_pointer_out = {z_reg, x_reg, y_reg};
    assign ram_wdata_out = acc_reg;
    assign ram_we_out = exec & (any_swap | acc_to_ram_xor_x);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_b_to_acc;
        exec && copy_b_to_acc |=> acc_reg == $past(b_reg) && b_reg == $past(b_reg);
    endproperty
    a_b_to_acc: assert property (p_b_to_acc) else $error("B copy wrong");

    property p_acc_to_b;
        exec && copy_acc_to_b |=> b_reg == $past(acc_reg) && acc_reg == $past(acc_reg);
    endproperty
    a_acc_to_b: assert property (p_acc_to_b) else $error("Acc to B wrong");

    property p_pack;
        exec && pack_b_acc_wide |=> wide_reg == {$past(b_reg), $past(acc_reg)};
    endproperty
    a_pack: assert property (p_pack) else $error("Pack wrong");

    property p_d_to_acc;
        exec && copy_d_to_acc |=> acc_reg[3] == 1'b0 && acc_reg[2:0] == d_reg;
    endproperty
    a_d_to_acc: assert property (p_d_to_acc) else $error("D copy wrong");

    property p_load_xy;
        exec && load_x_y_immediate |=> x_reg == $past(instr_in[7:4]) && y_reg == $past(instr_in[3:0]);
    endproperty
    a_load_xy: assert property (p_load_xy) else $error("X/Y load wrong");

    property p_lxy_chain;
        instr_valid_in && load_x_y_immediate ##1 instr_valid_in && load_x_y_immediate
            |=> x_reg == $past(x_reg) && y_reg == $past(y_reg);
    endproperty
    a_lxy_chain: assert property (p_lxy_chain) else $error("Chained load executed");

    property p_swap;
        exec && swap_acc_ram_xor_x |-> ram_we_out && ram_wdata_out == acc_reg
            ##1 acc_reg == $past(ram_rdata_in) && x_reg == ($past(x_reg) ^ $past(instr_in[3:0]));
    endproperty
    a_swap: assert property (p_swap) else $error("Swap wrong");

    property p_iny_skip;
        exec && increment_y && y_reg == 4'hF |=> y_reg == 4'h0 && skip_reg ##1 !$past(exec);
    endproperty
    a_iny_skip: assert property (p_iny_skip) else $error("Increment skip wrong");

    property p_dey_skip;
        exec && decrement_y |=> skip_reg == (y_reg == 4'hF);
    endproperty
    a_dey_skip: assert property (p_dey_skip) else $error("Decrement skip wrong");

    property p_load_z;
        exec && load_z_immediate |=> z_reg == $past(instr_in[1:0]);
    endproperty
    a_load_z: assert property (p_load_z) else $error("Z load wrong");
endmodule // rtx_exec

// [bench/rtx_ram_model.sv]
// Data RAM beside the executor: 1024 nibbles, cleared at start.
// Assumes the pointer and write strobe come from the executor.
`timescale 1ns/1ns
module rtx_ram_model (
    // Clock
    input wire logic clk_in,
    // Access
    input wire logic [9:0] ptr_in,
    input wire logic [3:0] wdata_in,
    input wire logic we_in,
    // Read data
    output logic [3:0] rdata_out
);
    logic [3:0] mem_reg [0:1023] = '{default: 4'h0};
    // Combinational read of the pointed word
    assign rdata_out = mem_reg[ptr_in];
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem_reg[ptr_in] <= wdata_in;
        end
    end
endmodule // rtx_ram_model

// [bench/rtx_exec_tb_top.sv]
// Self-checking bench for the executor with a RAM model.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
module rtx_exec_tb_top;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [9:0] instr_in = 10'h000;
    logic instr_valid_in = 1'b0;
    logic [2:0] stack_level_in = 3'h0;
    logic [3:0] rd, acc, b, x, y, wd;
    logic [1:0] z;
    logic [2:0] d;
    logic [7:0] wide;
    logic skip, we;
    logic [9:0] ptr;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    rtx_exec u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in),
        .instr_valid_in(instr_valid_in), .stack_level_in(stack_level_in), .ram_rdata_in(rd),
        .acc_out(acc), .b_out(b), .x_out(x), .y_out(y), .z_out(z), .d_out(d), .wide_out(wide),
        .skip_out(skip), .ram_pointer_out(ptr), .ram_wdata_out(wd), .ram_we_out(we));
    rtx_ram_model u_ram (.clk_in(clk_in), .ptr_in(ptr), .wdata_in(wd), .we_in(we), .rdata_out(rd));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic op(input logic [9:0] code);
        @(posedge clk_in);
        #1 instr_in = code;
        instr_valid_in = 1'b1;
        @(posedge clk_in);
        #1 instr_valid_in = 1'b0;
    endtask
    task automatic op2(input logic [9:0] code_a, input logic [9:0] code_b);
        @(posedge clk_in);
        #1 instr_in = code_a;
        instr_valid_in = 1'b1;
        @(posedge clk_in);
        #1 instr_in = code_b;
        @(posedge clk_in);
        #1 instr_valid_in = 1'b0;
    endtask
    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_xy();
        op(rtx_pkg::OP_LOAD_XY | 10'h05F);
        chk("x", 10'h005, x);
        chk("y", 10'h00F, y);
        op(rtx_pkg::OP_LOAD_XY | 10'h011);
        chk("x chained", 10'h005, x);
    endtask
    task automatic t_transfer();
        op(rtx_pkg::OP_COPY_Y_TO_ACC);
        chk("acc y", 10'h00F, acc);
        op(rtx_pkg::OP_COPY_ACC_TO_B);
        chk("b", 10'h00F, b);
        op(rtx_pkg::OP_LOAD_Z | 10'h002);
        chk("z", 10'h002, z);
        op(rtx_pkg::OP_COPY_Z_TO_ACC);
        chk("acc z", 10'h002, acc);
        op(rtx_pkg::OP_COPY_ACC_TO_Y);
        chk("y acc", 10'h002, y);
        op(rtx_pkg::OP_PACK);
        chk("wide", 10'h0F2, wide);
        op(rtx_pkg::OP_COPY_B_TO_ACC);
        chk("acc b", 10'h00F, acc);
        op(rtx_pkg::OP_COPY_ACC_TO_D);
        chk("d", 10'h007, d);
        op(rtx_pkg::OP_COPY_D_TO_ACC);
        chk("acc d", 10'h007, acc);
        op(rtx_pkg::OP_COPY_ACC_TO_B);
        op(rtx_pkg::OP_UNPACK);
        chk("b wide", 10'h00F, b);
        chk("acc wide", 10'h002, acc);
        stack_level_in = 3'h5;
        op(rtx_pkg::OP_READ_STACK);
        chk("acc stack", 10'h005, acc);
    endtask
    task automatic t_skip();
        op(rtx_pkg::OP_LOAD_XY | 10'h0AF);
        op(rtx_pkg::OP_COPY_X_TO_ACC);
        chk("acc x", 10'h00A, acc);
        op(rtx_pkg::OP_INCREMENT_Y);
        chk("y inc", 10'h000, y);
        chk("skip inc", 10'h001, skip);
        op(rtx_pkg::OP_LOAD_Z | 10'h001);
        chk("z skipped", 10'h002, z);
        op(rtx_pkg::OP_DECREMENT_Y);
        chk("y dec", 10'h00F, y);
        chk("skip dec", 10'h001, skip);
        op(rtx_pkg::OP_LOAD_Z | 10'h001);
        chk("z skipped", 10'h002, z);
    endtask
    task automatic t_ram();
        op(rtx_pkg::OP_ACC_TO_RAM | 10'h003);
        chk("mem 2af", 10'h00A, u_ram.mem_reg[10'h2AF]);
        chk("x tma", 10'h009, x);
        op(rtx_pkg::OP_READ_STACK);
        op(rtx_pkg::OP_SWAP | 10'h003);
        chk("acc swap", 10'h000, acc);
        chk("mem swap", 10'h005, u_ram.mem_reg[10'h29F]);
        chk("x y swap", 10'h0AF, {x, y});
        op(rtx_pkg::OP_RAM_TO_ACC | 10'h006);
        chk("acc tam", 10'h00A, acc);
        chk("x tam", 10'h00C, x);
        op(rtx_pkg::OP_SWAP_INC | 10'h001);
        chk("acc inc", 10'h000, acc);
        chk("mem inc", 10'h00A, u_ram.mem_reg[10'h2CF]);
        chk("x y inc", 10'h0D0, {x, y});
        op(rtx_pkg::OP_COPY_Y_TO_ACC);
        op(rtx_pkg::OP_READ_STACK);
        op(rtx_pkg::OP_SWAP_DEC | 10'h001);
        chk("acc dec", 10'h000, acc);
        chk("mem dec", 10'h005, u_ram.mem_reg[10'h2D0]);
        chk("x y dec", 10'h0CF, {x, y});
        chk("skip swap_acc_ram_dec_y", 10'h001, skip);
        op(rtx_pkg::OP_READ_STACK);
        op2(rtx_pkg::OP_LOAD_XY | 10'h012, rtx_pkg::OP_LOAD_XY | 10'h034);
        chk("x y back to back", 10'h012, {x, y});
    endtask
    // ----------------------------------------
    // Main sequence and timeout
    // ----------------------------------------
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        repeat (8) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        chk("acc rst", 10'h000, acc);
        t_xy();
        t_transfer();
        t_skip();
        t_ram();
        stop_test();
    end
endmodule // rtx_exec_tb_top
